// ---- hdl/cdv_pkg.sv ----
// constants and types shared by the clock divider block
package cdv_pkg;

	localparam logic [31:0] CDV_CTRL_OFFSET = 32'h00000000;
	localparam logic [31:0] CDV_STAT_OFFSET = 32'h00000004;

	localparam int CDV_CTRL_MR_BIT = 0;
	localparam int CDV_CTRL_STOP_BIT = 1;
	localparam int CDV_CTRL_SEL_A_BIT = 2;
	localparam int CDV_CTRL_SEL_B_BIT = 3;
	localparam logic [3:0] CDV_CTRL_RESET = 4'h0;

	localparam int CDV_STAT_PHASE_LSB = 0;
	localparam int CDV_STAT_FIRST_BIT = 4;
	localparam int CDV_STAT_SECOND_BIT = 5;
	localparam int CDV_STAT_STOP_BIT = 6;

	localparam int CDV_PHASE_W = 4;
	localparam logic [3:0] CDV_PHASE_RESET = 4'h0;
	localparam logic [3:0] CDV_PHASE_LAST = 4'hB;
	localparam logic [3:0] CDV_PHASE_STEP = 4'h1;

	localparam logic [3:0] CDV_FIRST_LO_HALF = 4'h1;
	localparam logic [3:0] CDV_FIRST_HI_HALF = 4'h2;
	localparam logic [3:0] CDV_SECOND_LO_HALF = 4'h2;
	localparam logic [3:0] CDV_SECOND_HI_HALF = 4'h3;

	localparam logic CDV_Q_RESET = 1'b0;
	localparam logic CDV_STOP_RESET = 1'b0;

	typedef struct packed {
		logic second_pair_ratio_select;
		logic first_pair_ratio_select;
		logic stop;
		logic master_reset;
	} cdv_ctrl_s;

	typedef struct packed {
		logic stopped;
		logic second_level;
		logic first_level;
		logic [3:0] phase;
	} cdv_stat_s;

	typedef enum logic [1:0] {
		CDV_RESP_OKAY = 2'b00,
		CDV_RESP_SLVERR = 2'b10
	} cdv_resp_e;

endpackage

// ---- hdl/cdv_tap.sv ----
// one differential output pair driven from the shared phase counter
`timescale 1ns/1ps
module cdv_tap import cdv_pkg::*; #(
	parameter logic [3:0] LO_HALF = 4'h1,
	parameter logic [3:0] HI_HALF = 4'h2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic master_reset,
	input wire logic advance,
	input wire logic ratio_sel,
	input wire logic [3:0] phase_next,
	output logic [1:0] q,
	output logic [1:0] q_n
);
	wire logic [3:0] half;
	wire logic [4:0] period;
	wire logic [4:0] rem;
	wire logic level;

	assign half = ratio_sel ? HI_HALF : LO_HALF;
	assign period = {half, 1'b0};
	// period always divides twelve, so all pairs meet at phase zero
	assign rem = {1'b0, phase_next} % period;
	assign level = rem >= {1'b0, half};

	always_ff @(posedge aclk) begin
		if (!aresetn || master_reset) begin
			q <= {2{CDV_Q_RESET}};
			q_n <= {2{~CDV_Q_RESET}};
		end else if (advance) begin
			q <= {2{level}};
			q_n <= {2{~level}};
		end
	end
endmodule // cdv_tap

// ---- hdl/cdv_axi.sv ----
// axi4-lite slave holding the control and status registers
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module cdv_axi import cdv_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire cdv_stat_s stat,
	output cdv_ctrl_s ctrl
);
	logic aw_got_reg;
	logic w_got_reg;
	logic [31:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic wstrb0_reg;
	cdv_ctrl_s ctrl_reg;

	wire logic aw_take;
	wire logic w_take;
	wire logic wr_do;
	wire logic wr_ctrl;
	wire logic wr_hit;
	wire logic ar_take;
	wire logic rd_ctrl;
	wire logic rd_stat;
	wire logic [31:0] rd_word;

	assign aw_take = awvalid && awready;
	assign w_take = wvalid && wready;
	assign wr_do = aw_got_reg && w_got_reg && !bvalid;
	assign wr_ctrl = waddr_reg[31:2] == CDV_CTRL_OFFSET[31:2];
	assign wr_hit = wr_ctrl || waddr_reg[31:2] == CDV_STAT_OFFSET[31:2];
	assign ar_take = arvalid && arready;
	assign rd_ctrl = araddr[31:2] == CDV_CTRL_OFFSET[31:2];
	assign rd_stat = araddr[31:2] == CDV_STAT_OFFSET[31:2];
	assign rd_word = rd_ctrl ? {28'h0000000, ctrl_reg} :
		rd_stat ? {25'h0000000, stat} : 32'h00000000;
	assign ctrl = ctrl_reg;

	// address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			awready <= 1'b0;
			waddr_reg <= 32'h00000000;
		end else begin
			awready <= !aw_got_reg && !aw_take && !bvalid;
			if (aw_take) begin
				aw_got_reg <= 1'b1;
				waddr_reg <= awaddr;
			end else if (wr_do) begin
				aw_got_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_reg <= 1'b0;
			wready <= 1'b0;
			wdata_reg <= 32'h00000000;
			wstrb0_reg <= 1'b0;
		end else begin
			wready <= !w_got_reg && !w_take && !bvalid;
			if (w_take) begin
				w_got_reg <= 1'b1;
				wdata_reg <= wdata;
				wstrb0_reg <= wstrb[0];
			end else if (wr_do) begin
				w_got_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CDV_CTRL_RESET;
			bvalid <= 1'b0;
			bresp <= CDV_RESP_OKAY;
		end else if (wr_do) begin
			bvalid <= 1'b1;
			bresp <= wr_hit ? CDV_RESP_OKAY : CDV_RESP_SLVERR;
			if (wr_ctrl && wstrb0_reg) begin
				ctrl_reg <= wdata_reg[3:0];
			end
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= CDV_RESP_OKAY;
		end else begin
			arready <= !rvalid && !ar_take;
			if (ar_take) begin
				rvalid <= 1'b1;
				rdata <= rd_word;
				rresp <= (rd_ctrl || rd_stat) ? CDV_RESP_OKAY :
					CDV_RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule // cdv_axi

// ---- hdl/cdv_top.sv ----
// synchronous divide by 2/4 and 4/6 clock generator with register access
`timescale 1ns/1ps
// Summary of operation
// - all divider stages step on the same input clock edge
// - enable changes only act while the internal clock is low
// - enable is captured by a falling-edge flip-flop
// - both pairs stay in step by construction without any reset
// - enable low, reset low: dividers advance on each rising edge
// - enable high: outputs freeze at their present state
// - master reset high forces all four outputs to reset state
// - first pair divides by 2 when select low, by 4 when high
// - two differential 2/4 outputs and two differential 4/6 outputs
module cdv_top import cdv_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic [1:0] half_quarter_outputs,
	output logic [1:0] half_quarter_outputs_n,
	output logic [1:0] quarter_sixth_outputs,
	output logic [1:0] quarter_sixth_outputs_n
);
	cdv_ctrl_s ctrl;
	cdv_stat_s stat;
	logic stop_fall_reg;
	logic [3:0] phase_reg;

	wire logic advance;
	wire logic [3:0] phase_next;

	cdv_axi u_axi (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.stat(stat),
		.ctrl(ctrl)
	);

	// sampled on the falling edge so a stop never clips a high phase
	always_ff @(negedge aclk) begin
		if (!aresetn) begin
			stop_fall_reg <= CDV_STOP_RESET;
		end else begin
			stop_fall_reg <= ctrl.stop;
		end
	end

	assign advance = !stop_fall_reg && !ctrl.master_reset;
	assign phase_next = (phase_reg == CDV_PHASE_LAST) ? CDV_PHASE_RESET :
		phase_reg + CDV_PHASE_STEP;

	// one shared counter feeds both pairs, keeping them aligned
	always_ff @(posedge aclk) begin
		if (!aresetn || ctrl.master_reset) begin
			phase_reg <= CDV_PHASE_RESET;
		end else if (advance) begin
			phase_reg <= phase_next;
		end
	end

	assign stat = '{stopped: stop_fall_reg,
		second_level: quarter_sixth_outputs[0],
		first_level: half_quarter_outputs[0],
		phase: phase_reg};

	cdv_tap #(
		.LO_HALF(CDV_FIRST_LO_HALF),
		.HI_HALF(CDV_FIRST_HI_HALF)
	) u_first (
		.aclk(aclk),
		.aresetn(aresetn),
		.master_reset(ctrl.master_reset),
		.advance(advance),
		.ratio_sel(ctrl.first_pair_ratio_select),
		.phase_next(phase_next),
		.q(half_quarter_outputs),
		.q_n(half_quarter_outputs_n)
	);

	cdv_tap #(
		.LO_HALF(CDV_SECOND_LO_HALF),
		.HI_HALF(CDV_SECOND_HI_HALF)
	) u_second (
		.aclk(aclk),
		.aresetn(aresetn),
		.master_reset(ctrl.master_reset),
		.advance(advance),
		.ratio_sel(ctrl.second_pair_ratio_select),
		.phase_next(phase_next),
		.q(quarter_sixth_outputs),
		.q_n(quarter_sixth_outputs_n)
	);
endmodule // cdv_top

// ---- verif/cdv_monitor.sv ----
// concurrent checks on divider outputs and bus answers
`timescale 1ns/1ps
module cdv_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [1:0] half_quarter_outputs,
	input wire logic [1:0] half_quarter_outputs_n,
	input wire logic [1:0] quarter_sixth_outputs,
	input wire logic [1:0] quarter_sixth_outputs_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rd_take;
		arvalid && arready;
	endsequence
	pair_one_cmp_a: assert property (
		half_quarter_outputs_n == ~half_quarter_outputs)
		else $error("first pair not complementary");
	pair_two_cmp_a: assert property (
		quarter_sixth_outputs_n == ~quarter_sixth_outputs)
		else $error("second pair not complementary");
	lanes_equal_a: assert property (
		^half_quarter_outputs == 1'b0 && ^quarter_sixth_outputs == 1'b0)
		else $error("output lanes differ");
	reset_clear_a: assert property (
		$rose(aresetn) |->
		{half_quarter_outputs, quarter_sixth_outputs} == 4'h0)
		else $error("outputs not cleared by reset");
	// response is registered after both halves are latched: two edges
	wr_answer_a: assert property (wr_take |=>
		!awready && !wready ##1 bvalid)
		else $error("write not answered");
	rd_answer_a: assert property (rd_take |=> rvalid && !arready)
		else $error("read not answered");
	resp_hold_a: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped");
	data_hold_a: assert property (rvalid && !rready |=> rvalid)
		else $error("read data dropped");
	resp_drop_a: assert property (bvalid && bready |=> !bvalid)
		else $error("write response repeated");
endmodule // cdv_monitor
bind cdv_top cdv_monitor i_mon (.aclk, .aresetn, .awvalid, .awready, .wvalid,
	.wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready,
	.half_quarter_outputs, .half_quarter_outputs_n, .quarter_sixth_outputs,
	.quarter_sixth_outputs_n);

// ---- verif/cdv_host.sv ----
// axi4-lite master standing in for the board control logic
`timescale 1ns/1ps
module cdv_host (
	input wire logic aclk,
	output logic [31:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [31:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// leading edge keeps back to back calls from double driving bready
	task automatic wr(input logic [31:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule // cdv_host

// ---- verif/test_sync_clock_divider_2_4_6.sv ----
// self-checking bench for the 2/4 and 4/6 clock divider
`timescale 1ns/1ps
module test_sync_clock_divider_2_4_6 import cdv_pkg::*; ();
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata, d;
	logic [31:0] lfsr = 32'h49B53565;
	logic [3:0] wstrb, v;
	logic [1:0] bresp, rresp, hq, hq_n, qs, qs_n, r;
	int n_errors = 0, num_checks = 0, cyc = 0, p, ha, hb;
	cdv_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.half_quarter_outputs(hq), .half_quarter_outputs_n(hq_n),
		.quarter_sixth_outputs(qs), .quarter_sixth_outputs_n(qs_n));
	cdv_host i_host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready);
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic lvl(input int ph, input int h);
		return (ph % (2 * h)) >= h;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			test_done();
		end
	end
	initial begin
		aresetn = 1'b0;
		@(negedge aclk);
		chk({hq, qs}, 4'h0, "reset");
		@(posedge aclk);
		aresetn <= 1'b1;
		i_host.rd(CDV_CTRL_OFFSET, d, r);
		chk(d, {28'h0, CDV_CTRL_RESET}, "ctrl reset");
		// every select pair, upper data bits random
		for (int s = 0; s < 4; s++) begin
			lfsr = step(lfsr);
			d = {lfsr[31:4], s[1:0], 2'h1};
			i_host.wr(CDV_CTRL_OFFSET, d, r);
			repeat (2) @(negedge aclk);
			chk({hq, qs}, 4'h0, "master reset");
			d[0] = 1'b0;
			i_host.wr(CDV_CTRL_OFFSET, d, r);
			ha = s[0] ? 2 : 1;
			hb = s[1] ? 3 : 2;
			p = 0;
			do begin
				@(negedge aclk);
				p++;
			end while (hq[0] !== 1'b1 && p < 20);
			p = ha;
			repeat (24) begin
				chk({hq, qs}, {{2{lvl(p, ha)}}, {2{lvl(p, hb)}}}, "ratio");
				chk({hq_n, qs_n}, {~hq, ~qs}, "complement");
				@(negedge aclk);
				p = (p + 1) % 12;
			end
			$display("mode %0d done", s);
		end
		i_host.wr(CDV_CTRL_OFFSET, 32'h00000002, r);
		repeat (2) @(negedge aclk);
		v = {hq, qs};
		repeat (8) begin
			@(negedge aclk);
			chk({hq, qs}, v, "hold");
		end
		i_host.rd(CDV_STAT_OFFSET, d, r);
		chk(d[CDV_STAT_STOP_BIT], 1'b1, "stop flag");
		i_host.wr(CDV_CTRL_OFFSET, 32'h00000000, r);
		repeat (3) @(negedge aclk);
		v = {hq, qs};
		@(negedge aclk);
		chk(hq, {~v[3:2]}, "resume");
		$display("hold done");
		i_host.wr(CDV_STAT_OFFSET, lfsr, r);
		chk(r, CDV_RESP_OKAY, "status write");
		lfsr = step(lfsr);
		i_host.wr(32'h00000008, lfsr, r);
		chk(r, CDV_RESP_SLVERR, "bad write");
		i_host.rd(32'h00000008, d, r);
		chk(r, CDV_RESP_SLVERR, "bad read");
		$display("bus done");
		test_done();
	end
endmodule // test_sync_clock_divider_2_4_6
